/* design/mem_map_pkg.sv */
package mem_map_pkg;
    // Program space layout
    localparam int PA_W = 24;
    localparam int PROG_IMPL_W = 24;
    localparam logic [23:0] RESET_ADDR = 24'h000000;
    localparam logic [23:0] GOTO_TGT_ADDR = 24'h000002;
    localparam logic [23:0] VEC_AREA_END = 24'h000200;
    localparam logic [23:0] VT0_LO = 24'h000004;
    localparam logic [23:0] VT0_HI = 24'h0000FF;
    localparam logic [23:0] VT1_LO = 24'h000104;
    localparam logic [23:0] VT1_HI = 24'h0001FF;
    localparam logic [23:0] EE_LO = 24'h7FFE00;
    localparam logic [23:0] EE_HI = 24'h7FFFFF;
    localparam logic [23:0] USER_TOP = 24'h7FFFFF;
    localparam logic [23:0] CFG_FIRST = 24'hF80000;
    localparam logic [23:0] CFG_SECOND = 24'hF80004;
    localparam logic [23:0] CFG_LAST = 24'hF8000E;
    localparam int CFG_WORDS = 7;
    localparam int EE_WORDS = 256;
    localparam logic [23:0] PC_STEP = 24'h000002;
    localparam logic [23:0] PC_MASK = 24'h7FFFFE;
    // Data space layout
    localparam int DW = 16;
    localparam logic [15:0] BYTE_STEP = 16'h0001;
    localparam logic [15:0] WORD_STEP = 16'h0002;
    localparam logic [15:0] SFR_TOP = 16'h07FF;
    localparam logic [15:0] RAM_BASE = 16'h0800;
    localparam int RAM_WORDS = 1024;
    localparam int RAM_AW = 10;
    localparam logic [15:0] NEAR_TOP = 16'h1FFF;
    localparam int NEAR_W = 13;
    localparam int WIN_BIT = 15;
    localparam int WIN_EN_BIT = 2;

    typedef enum logic [1:0] {AM_INDIRECT, AM_NEAR, AM_FULL} addr_mode_t;
    typedef enum logic [2:0] {
        REG_NONE, REG_WORD, REG_BYTE, REG_SIGN_EXT, REG_ZERO_EXT
    } reg_op_t;

    typedef struct packed {
        logic reset_vec;
        logic goto_tgt;
        logic vec_area;
        logic vt0;
        logic vt1;
        logic user;
        logic eeprom;
        logic cfg;
        logic [2:0] cfg_idx;
        logic [7:0] ee_idx;
    } prog_region_t;
endpackage : mem_map_pkg

/* design/lane_if.sv */
`timescale 1ns/10ps
interface lane_if;
    logic rd_byte;
    logic rd_lsb;
    logic [15:0] mem_word;
    logic [15:0] rd_value;
    logic wr_byte;
    logic wr_lsb;
    logic [15:0] wr_src;
    logic [1:0] lane_we;
    logic [15:0] lane_data;
    mem_map_pkg::reg_op_t reg_op;
    logic [15:0] reg_old;
    logic [15:0] reg_new;

    modport core (output rd_byte, rd_lsb, mem_word, wr_byte, wr_lsb,
        wr_src, reg_op, reg_old, input rd_value, lane_we, lane_data,
        reg_new);
    modport lane (input rd_byte, rd_lsb, mem_word, wr_byte, wr_lsb,
        wr_src, reg_op, reg_old, output rd_value, lane_we, lane_data,
        reg_new);
endinterface : lane_if

/* design/byte_lane_unit.sv */
`timescale 1ns/10ps
module byte_lane_unit (
    lane_if.lane lanes
);
    // Read lane pick and write strobes
    always_comb
    begin
        if (lanes.rd_byte)
        begin
            lanes.rd_value = {8'h00, lanes.rd_lsb ? lanes.mem_word[15:8]
                : lanes.mem_word[7:0]};
        end
        else
        begin
            lanes.rd_value = lanes.mem_word;
        end
        if (lanes.wr_byte)
        begin
            lanes.lane_we = lanes.wr_lsb ? 2'h2 : 2'h1;
        end
        else
        begin
            lanes.lane_we = 2'h3;
        end
        // Byte data is copied onto both lanes; the strobe picks one
        lanes.lane_data = lanes.wr_byte ?
            {lanes.wr_src[7:0], lanes.wr_src[7:0]} : lanes.wr_src;
    end

    // Working register merge for loads and extend operations
    always_comb
    begin
        case (lanes.reg_op)
            mem_map_pkg::REG_WORD: lanes.reg_new = lanes.rd_value;
            mem_map_pkg::REG_BYTE:
                lanes.reg_new = {lanes.reg_old[15:8],
                    lanes.rd_value[7:0]};
            mem_map_pkg::REG_SIGN_EXT:
                lanes.reg_new = {{8{lanes.reg_old[7]}},
                    lanes.reg_old[7:0]};
            mem_map_pkg::REG_ZERO_EXT:
                lanes.reg_new = {8'h00, lanes.reg_old[7:0]};
            default: lanes.reg_new = lanes.reg_old;
        endcase
    end
endmodule : byte_lane_unit

/* design/prog_addr_decode.sv */
`timescale 1ns/10ps
module prog_addr_decode (
    input wire logic [23:0] addr,
    output mem_map_pkg::prog_region_t region
);
    logic [23:0] cfg_off;

    // Region flags for one program address
    always_comb
    begin
        cfg_off = addr - mem_map_pkg::CFG_SECOND;
        region = '0;
        region.reset_vec = addr == mem_map_pkg::RESET_ADDR;
        region.goto_tgt = addr == mem_map_pkg::GOTO_TGT_ADDR;
        region.vec_area = addr < mem_map_pkg::VEC_AREA_END;
        region.vt0 = addr >= mem_map_pkg::VT0_LO &&
            addr <= mem_map_pkg::VT0_HI;
        region.vt1 = addr >= mem_map_pkg::VT1_LO &&
            addr <= mem_map_pkg::VT1_HI;
        region.user = addr <= mem_map_pkg::USER_TOP;
        region.eeprom = addr >= mem_map_pkg::EE_LO &&
            addr <= mem_map_pkg::EE_HI;
        region.ee_idx = addr[8:1];
        // Second word sits four apart from the first, rest are packed
        if (addr == mem_map_pkg::CFG_FIRST)
        begin
            region.cfg = 1'b1;
        end
        else if (addr >= mem_map_pkg::CFG_SECOND &&
            addr <= mem_map_pkg::CFG_LAST && !addr[0])
        begin
            region.cfg = 1'b1;
            region.cfg_idx = cfg_off[3:1] + 3'h1;
        end
    end
endmodule : prog_addr_decode

/* design/memory_space_address_decode.sv */
`timescale 1ns/10ps
// Functional notes
// - Program location: even low half, odd high
// - PC stays even, steps by two
// - Reset starts at zero, jump target follows
// - Two vector tables give handler addresses
// - Nonvolatile words at top of user space
// - Seven configuration words at fixed addresses
// - Separate read and write address generators
// - Sixteen-bit byte effective addresses
// - Bit 15 picks memory or window
// - Unimplemented data reads return zero
// - Low byte even, high byte odd
// - Pointer step one for byte, two word
// - Byte read selects lane onto low bits
// - Shared decode, per-lane write strobes
// - Odd word access raises address error
// - Read completes, write suppressed, then trap
// - Byte load keeps register high byte
// - Sign extend and zero extend operations
// - Near field reaches 0000h to 1FFFh
// - Full sixteen-bit direct field reaches all
// - Control bit 2 enables program window
// - Plain accesses stay below top half
// - Register region reads zero where empty
module memory_space_address_decode (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [15:0] processor_control_register,
    input wire logic [7:0] window_page,
    input wire logic pc_advance,
    input wire logic pc_retreat,
    input wire logic pc_load,
    input wire logic [23:0] pc_target,
    output logic [23:0] pc_addr,
    output mem_map_pkg::prog_region_t pc_region,
    input wire logic tbl_req,
    input wire logic [23:0] tbl_addr,
    output mem_map_pkg::prog_region_t tbl_region,
    output logic tbl_ok,
    input wire logic irq_alt_table,
    input wire logic [6:0] irq_source,
    output logic [23:0] vector_ptr,
    output logic vector_ok,
    input wire logic rd_req,
    input wire mem_map_pkg::addr_mode_t rd_mode,
    input wire logic [15:0] rd_field,
    input wire logic rd_byte,
    input wire logic rd_post_dec,
    output logic [15:0] rd_ea,
    output logic [15:0] rd_data,
    output logic rd_valid,
    output logic [15:0] rd_ptr_next,
    input wire logic wr_req,
    input wire mem_map_pkg::addr_mode_t wr_mode,
    input wire logic [15:0] wr_field,
    input wire logic wr_byte,
    input wire logic wr_post_dec,
    input wire logic [15:0] wr_data,
    output logic [15:0] wr_ea,
    output logic [15:0] wr_ptr_next,
    output logic sfr_rd_en,
    input wire logic sfr_rd_ack,
    input wire logic [15:0] sfr_rd_word,
    output logic [1:0] sfr_wr_strobe,
    output logic [15:0] sfr_wr_data,
    output logic win_rd_en,
    output logic [23:0] win_prog_addr,
    input wire logic [15:0] win_rd_word,
    input wire mem_map_pkg::reg_op_t reg_op,
    input wire logic [15:0] reg_old,
    output logic [15:0] reg_new,
    output logic reg_new_valid,
    output logic addr_err_trap,
    output logic err_on_read,
    output logic err_on_write,
    input wire logic trap_ack
);
    typedef enum logic {ST_RUN, ST_TRAP} trap_state_t;

    typedef struct packed {
        trap_state_t st;
        logic [23:0] pc;
        mem_map_pkg::prog_region_t tbl_region;
        logic tbl_ok;
        logic [23:0] vec_ptr;
        logic vec_ok;
        logic [15:0] rd_data;
        logic rd_valid;
        logic [15:0] rd_ptr;
        logic [15:0] wr_ptr;
        logic [15:0] reg_new;
        logic reg_valid;
        logic err_read;
        logic err_write;
    } state_t;

    state_t state_q;
    state_t state_d;
    logic [15:0] ram_q [mem_map_pkg::RAM_WORDS];
    mem_map_pkg::prog_region_t tbl_dec;
    logic win_en;
    logic rd_misaligned;
    logic wr_misaligned;
    logic wr_commit;
    logic ram_wr_hit;
    logic [15:0] rd_word;
    logic [15:0] rd_aligned;
    logic [23:0] vec_base;
    logic [23:0] vec_addr;

    lane_if lanes ();

    // Effective address from the addressing mode
    function automatic logic [15:0] calc_ea(
        input mem_map_pkg::addr_mode_t mode,
        input logic [15:0] field
    );
        if (mode == mem_map_pkg::AM_NEAR)
        begin
            // Near field reaches only the bottom 8 Kbytes
            calc_ea = {3'h0, field[mem_map_pkg::NEAR_W-1:0]};
        end
        else
        begin
            calc_ea = field;
        end
    endfunction : calc_ea

    // Post-modified pointer value scaled by operand size
    function automatic logic [15:0] next_ptr(
        input logic [15:0] ea,
        input logic is_byte,
        input logic dec
    );
        logic [15:0] step;
        step = is_byte ? mem_map_pkg::BYTE_STEP : mem_map_pkg::WORD_STEP;
        next_ptr = dec ? ea - step : ea + step;
    endfunction : next_ptr

    // Data RAM hit, below the window half only
    function automatic logic in_ram(input logic [15:0] ea);
        in_ram = !ea[mem_map_pkg::WIN_BIT] &&
            ea >= mem_map_pkg::RAM_BASE &&
            ea < mem_map_pkg::RAM_BASE + 16'(2 * mem_map_pkg::RAM_WORDS);
    endfunction : in_ram

    // Word index in the RAM; byte bit is dropped
    function automatic logic [9:0] ram_index(input logic [15:0] ea);
        logic [15:0] off;
        off = ea - mem_map_pkg::RAM_BASE;
        ram_index = off[10:1];
    endfunction : ram_index

    // True for a register-region address
    function automatic logic in_sfr(input logic [15:0] ea);
        in_sfr = ea <= mem_map_pkg::SFR_TOP;
    endfunction : in_sfr

    byte_lane_unit u_lanes (
        .lanes(lanes.lane)
    );

    prog_addr_decode u_pc_dec (
        .addr(state_q.pc),
        .region(pc_region)
    );

    prog_addr_decode u_tbl_dec (
        .addr(tbl_addr),
        .region(tbl_dec)
    );

    // Both address generators work every cycle, independently
    assign rd_ea = calc_ea(rd_mode, rd_field);
    assign wr_ea = calc_ea(wr_mode, wr_field);
    assign win_en = processor_control_register[mem_map_pkg::WIN_EN_BIT];

    // Odd address on a word access is an address error
    assign rd_misaligned = rd_req && !rd_byte && rd_ea[0];
    assign wr_misaligned = wr_req && !wr_byte && wr_ea[0];
    assign wr_commit = wr_req && !wr_misaligned;
    assign ram_wr_hit = wr_commit && in_ram(wr_ea);

    // A misaligned read still completes on the containing word
    assign rd_aligned = {rd_ea[15:1], 1'b0};

    // Program window: page on top of the low 15 address bits
    assign win_rd_en = rd_req && rd_ea[mem_map_pkg::WIN_BIT] &&
        win_en;
    assign win_prog_addr = {1'b0, window_page, rd_aligned[14:0]};
    assign sfr_rd_en = rd_req && in_sfr(rd_ea);

    // Register region writes; lane strobes gate the write data
    assign sfr_wr_strobe = (wr_commit && in_sfr(wr_ea)) ?
        lanes.lane_we : 2'h0;
    assign sfr_wr_data = lanes.lane_data;

    // Raw word from whichever region the read address falls in
    always_comb
    begin
        if (rd_ea[mem_map_pkg::WIN_BIT])
        begin
            // Hidden window reads as zero
            rd_word = win_en ? win_rd_word : 16'h0000;
        end
        else if (in_sfr(rd_ea))
        begin
            rd_word = sfr_rd_ack ? sfr_rd_word : 16'h0000;
        end
        else if (in_ram(rd_ea))
        begin
            rd_word = ram_q[ram_index(rd_aligned)];
        end
        else
        begin
            rd_word = 16'h0000;
        end
    end

    // Feed the lane unit from both address generators
    assign lanes.rd_byte = rd_byte;
    assign lanes.rd_lsb = rd_ea[0];
    assign lanes.mem_word = rd_word;
    assign lanes.wr_byte = wr_byte;
    assign lanes.wr_lsb = wr_ea[0];
    assign lanes.wr_src = wr_data;
    assign lanes.reg_op = reg_op;
    assign lanes.reg_old = reg_old;

    // Handler address inside the selected vector table
    assign vec_base = irq_alt_table ? mem_map_pkg::VT1_LO :
        mem_map_pkg::VT0_LO;
    assign vec_addr = vec_base + {16'h0000, irq_source, 1'b0};

    // Next-state logic for all control state
    always_comb
    begin
        state_d = state_q;

        // Program counter stays even and in the user half
        if (pc_load)
        begin
            state_d.pc = pc_target & mem_map_pkg::PC_MASK;
        end
        else if (pc_advance)
        begin
            state_d.pc = (state_q.pc + mem_map_pkg::PC_STEP) &
                mem_map_pkg::PC_MASK;
        end
        else if (pc_retreat)
        begin
            state_d.pc = (state_q.pc - mem_map_pkg::PC_STEP) &
                mem_map_pkg::PC_MASK;
        end

        // Table operations may also reach configuration words
        if (tbl_req)
        begin
            state_d.tbl_region = tbl_dec;
            state_d.tbl_ok = tbl_dec.user || tbl_dec.cfg;
        end

        // Vector pointer, flagged when it runs past its table
        state_d.vec_ptr = vec_addr;
        state_d.vec_ok = irq_alt_table ?
            vec_addr <= mem_map_pkg::VT1_HI :
            vec_addr <= mem_map_pkg::VT0_HI;

        // Read result and register merge land one cycle later
        state_d.rd_valid = rd_req;
        state_d.reg_valid = rd_req && reg_op != mem_map_pkg::REG_NONE;
        if (rd_req)
        begin
            state_d.rd_data = lanes.rd_value;
            state_d.reg_new = lanes.reg_new;
            state_d.rd_ptr = next_ptr(rd_ea, rd_byte, rd_post_dec);
        end
        else if (reg_op == mem_map_pkg::REG_SIGN_EXT ||
            reg_op == mem_map_pkg::REG_ZERO_EXT)
        begin
            // Extend operations need no memory read
            state_d.reg_new = lanes.reg_new;
            state_d.reg_valid = 1'b1;
        end
        if (wr_req)
        begin
            state_d.wr_ptr = next_ptr(wr_ea, wr_byte, wr_post_dec);
        end

        // Trap sequencing; a new error wins over the acknowledge
        case (state_q.st)
            ST_RUN:
            begin
                if (rd_misaligned || wr_misaligned)
                begin
                    state_d.st = ST_TRAP;
                    state_d.err_read = rd_misaligned;
                    state_d.err_write = wr_misaligned;
                end
            end
            ST_TRAP:
            begin
                if (rd_misaligned || wr_misaligned)
                begin
                    state_d.err_read = state_q.err_read || rd_misaligned;
                    state_d.err_write = state_q.err_write || wr_misaligned;
                end
                else if (trap_ack)
                begin
                    state_d.st = ST_RUN;
                    state_d.err_read = 1'b0;
                    state_d.err_write = 1'b0;
                end
            end
            default:
            begin
                state_d.st = ST_RUN;
            end
        endcase
    end

    // State register; ST_RUN encodes as zero, so reset is all zeros
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_q <= '0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // Data RAM with one write strobe per byte lane, no reset needed
    always_ff @(posedge sys_clk)
    begin
        if (ram_wr_hit && lanes.lane_we[0])
        begin
            ram_q[ram_index(wr_ea)][7:0] <= lanes.lane_data[7:0];
        end
        if (ram_wr_hit && lanes.lane_we[1])
        begin
            ram_q[ram_index(wr_ea)][15:8] <= lanes.lane_data[15:8];
        end
    end

    // Outputs straight from the state register
    assign pc_addr = state_q.pc;
    assign tbl_region = state_q.tbl_region;
    assign tbl_ok = state_q.tbl_ok;
    assign vector_ptr = state_q.vec_ptr;
    assign vector_ok = state_q.vec_ok;
    assign rd_data = state_q.rd_data;
    assign rd_valid = state_q.rd_valid;
    assign rd_ptr_next = state_q.rd_ptr;
    assign wr_ptr_next = state_q.wr_ptr;
    assign reg_new = state_q.reg_new;
    assign reg_new_valid = state_q.reg_valid;
    assign addr_err_trap = state_q.st == ST_TRAP;
    assign err_on_read = state_q.err_read;
    assign err_on_write = state_q.err_write;
endmodule : memory_space_address_decode

/* dv/mem_map_props.sv */
`timescale 1ns/10ps
module mem_map_props (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [15:0] processor_control_register,
    input wire logic pc_advance,
    input wire logic pc_load,
    input wire logic [23:0] pc_target,
    input wire logic [23:0] pc_addr,
    input wire logic rd_req,
    input wire logic rd_byte,
    input wire logic [15:0] rd_ea,
    input wire logic [15:0] rd_data,
    input wire logic wr_req,
    input wire logic wr_byte,
    input wire logic [15:0] wr_ea,
    input wire logic [1:0] sfr_wr_strobe,
    input wire logic addr_err_trap
);
    // One clock domain, so clocking and disable are stated once
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    property p_pc_step;
        pc_advance && !pc_load |=>
            pc_addr == (($past(pc_addr) + 24'h000002) & 24'h7FFFFE);
    endproperty
    a_pc_step: assert property (p_pc_step)
        else $error("pc did not step by two");

    property p_pc_load;
        pc_load |=> pc_addr == ($past(pc_target) & 24'h7FFFFE);
    endproperty
    a_pc_load: assert property (p_pc_load)
        else $error("loaded pc not masked to user half");

    property p_win_hidden;
        rd_req && rd_ea[15] && !processor_control_register[2] |=>
            rd_data == 16'h0000;
    endproperty
    a_win_hidden: assert property (p_win_hidden)
        else $error("hidden window read not zero");

    property p_unimpl;
        rd_req && !rd_ea[15] && rd_ea > 16'h0FFF |=> rd_data == 16'h0000;
    endproperty
    a_unimpl: assert property (p_unimpl)
        else $error("unimplemented read not zero");

    property p_byte_rd;
        rd_req && rd_byte |=> rd_data[15:8] == 8'h00;
    endproperty
    a_byte_rd: assert property (p_byte_rd)
        else $error("byte read upper bits not clear");

    // Trap may land one or two edges after the faulting request
    property p_mis_trap;
        (rd_req && !rd_byte && rd_ea[0]) || (wr_req && !wr_byte && wr_ea[0])
            |-> ##[1:2] addr_err_trap;
    endproperty
    a_mis_trap: assert property (p_mis_trap)
        else $error("odd word access raised no trap");

    property p_mis_nostrobe;
        wr_req && !wr_byte && wr_ea[0] |-> sfr_wr_strobe == 2'b00;
    endproperty
    a_mis_nostrobe: assert property (p_mis_nostrobe)
        else $error("odd word write strobed a lane");

    property p_byte_strobe;
        wr_req && wr_byte && wr_ea <= 16'h07FF |->
            sfr_wr_strobe == {wr_ea[0], !wr_ea[0]};
    endproperty
    a_byte_strobe: assert property (p_byte_strobe)
        else $error("byte write strobe on wrong lane");

    c_byte_rd: cover property (rd_req && rd_byte);
    c_trap: cover property ($rose(addr_err_trap));
    c_win: cover property (rd_req && rd_ea[15] && processor_control_register[2]);
endmodule : mem_map_props

bind memory_space_address_decode mem_map_props chk_u (.*);

/* dv/far_side_model.sv */
`timescale 1ns/10ps
module far_side_model (
    input wire logic sys_clk,
    input wire logic [15:0] rd_ea,
    input wire logic sfr_rd_en,
    output logic sfr_rd_ack,
    output logic [15:0] sfr_rd_word,
    input wire logic win_rd_en,
    input wire logic [23:0] win_prog_addr,
    output logic [15:0] win_rd_word
);
    logic [15:0] churn_q = 16'h0F0F;

    // Churning filler, so an unselected bus never repeats a stale word
    always @(posedge sys_clk)
        churn_q <= churn_q + 16'h1357;

    // Only the bottom 256 bytes of the register region answer
    assign sfr_rd_ack = sfr_rd_en && (rd_ea < 16'h0100);
    assign sfr_rd_word = sfr_rd_ack ? ({rd_ea[15:1], 1'b0} ^ 16'h5A5A)
        : churn_q;
    // Program store gives a word tied to the address it was asked for
    assign win_rd_word = win_rd_en ? (win_prog_addr[15:0] ^ 16'h3C3C)
        : ~churn_q;
endmodule : far_side_model

/* dv/memory_space_address_decode_tb.sv */
`timescale 1ns/10ps
module memory_space_address_decode_tb;
    typedef struct packed {
        logic n; logic [15:0] f; logic b; logic w;
        logic [15:0] d; logic [15:0] p; } row_t;
    logic sys_clk, nrst, pc_advance, pc_retreat, pc_load, tbl_req;
    logic irq_alt_table, rd_req, rd_byte, rd_post_dec, wr_req, wr_byte;
    logic wr_post_dec, trap_ack, rd_valid, tbl_ok, vector_ok, sfr_rd_en;
    logic sfr_rd_ack, win_rd_en, reg_new_valid, addr_err_trap;
    logic err_on_read, err_on_write;
    logic [15:0] processor_control_register, rd_field, rd_ea, rd_data;
    logic [15:0] rd_ptr_next, wr_field, wr_data, wr_ea, wr_ptr_next;
    logic [15:0] sfr_rd_word, sfr_wr_data, win_rd_word, reg_old, reg_new;
    logic [23:0] pc_target, pc_addr, tbl_addr, vector_ptr, win_prog_addr;
    logic [7:0] window_page;
    logic [6:0] irq_source;
    logic [1:0] sfr_wr_strobe;
    mem_map_pkg::prog_region_t pc_region, tbl_region;
    mem_map_pkg::addr_mode_t rd_mode, wr_mode;
    mem_map_pkg::reg_op_t reg_op;
    int n_mismatch = 0;
    int n_compared = 0;
    int cycles = 0;
    // Reads after RAM word 0800 holds AB34; window page is 01
    row_t rows [9] = '{
        '{1'b0, 16'h0800, 1'b0, 1'b0, 16'hAB34, 16'h0802},
        '{1'b0, 16'h0800, 1'b1, 1'b0, 16'h0034, 16'h0801},
        '{1'b0, 16'h0801, 1'b1, 1'b0, 16'h00AB, 16'h0802},
        '{1'b1, 16'h2800, 1'b0, 1'b0, 16'hAB34, 16'h0802},
        '{1'b0, 16'h1000, 1'b0, 1'b0, 16'h0000, 16'h1002},
        '{1'b0, 16'h0010, 1'b0, 1'b0, 16'h5A4A, 16'h0012},
        '{1'b0, 16'h0400, 1'b0, 1'b0, 16'h0000, 16'h0402},
        '{1'b0, 16'h8004, 1'b0, 1'b0, 16'h0000, 16'h8006},
        '{1'b0, 16'h8004, 1'b0, 1'b1, 16'hBC38, 16'h8006}};

    memory_space_address_decode dut_u (.*);
    far_side_model far_u (.*);

    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // Ceiling far above the ~90-cycle sequence
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            n_mismatch++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic rd(input mem_map_pkg::addr_mode_t m,
        input logic [15:0] f, input logic b, input logic d);
        @(negedge sys_clk);
        rd_mode = m;
        rd_field = f;
        rd_byte = b;
        rd_post_dec = d;
        rd_req = 1'b1;
        @(negedge sys_clk);
        rd_req = 1'b0;
        chk(rd_valid, 1'b1);
    endtask : rd

    // Strobes are combinational, so they are looked at before the edge
    task automatic wr(input logic [15:0] a, input logic b,
        input logic [15:0] v, input logic [1:0] st);
        @(negedge sys_clk);
        wr_field = a;
        wr_byte = b;
        wr_data = v;
        wr_req = 1'b1;
        #1 chk(sfr_wr_strobe, st);
        chk(sfr_wr_data, b ? {2{v[7:0]}} : v);
        @(negedge sys_clk);
        wr_req = 1'b0;
    endtask : wr

    task automatic pcop(input logic [2:0] alr, input logic [23:0] t, e);
        @(negedge sys_clk);
        {pc_advance, pc_load, pc_retreat} = alr;
        pc_target = t;
        @(negedge sys_clk);
        {pc_advance, pc_load, pc_retreat} = 3'b000;
        chk(pc_addr, e);
    endtask : pcop

    task automatic tq(input logic [23:0] a);
        @(negedge sys_clk);
        tbl_addr = a;
        tbl_req = 1'b1;
        @(negedge sys_clk);
        tbl_req = 1'b0;
    endtask : tq

    task automatic trap_chk(input logic r, input logic w);
        @(negedge sys_clk);
        chk({addr_err_trap, err_on_read, err_on_write}, {1'b1, r, w});
        trap_ack = 1'b1;
        @(negedge sys_clk);
        trap_ack = 1'b0;
        @(negedge sys_clk);
        chk(addr_err_trap, 1'b0);
    endtask : trap_chk

    task automatic ext(input mem_map_pkg::reg_op_t op,
        input logic [15:0] o, e);
        @(negedge sys_clk);
        reg_op = op;
        reg_old = o;
        @(negedge sys_clk);
        reg_op = mem_map_pkg::REG_NONE;
        chk({reg_new_valid, reg_new}, {1'b1, e});
    endtask : ext

    initial
    begin
        nrst = 1'b0;
        {pc_advance, pc_retreat, pc_load, tbl_req, rd_req, wr_req} = 6'h00;
        {irq_alt_table, rd_byte, rd_post_dec, wr_byte, wr_post_dec} = 5'h00;
        trap_ack = 1'b0;
        processor_control_register = 16'h0000;
        window_page = 8'h01;
        irq_source = 7'h03;
        {pc_target, tbl_addr} = 48'h0;
        {rd_field, wr_field, wr_data, reg_old} = 64'h0;
        rd_mode = mem_map_pkg::AM_FULL;
        wr_mode = mem_map_pkg::AM_FULL;
        reg_op = mem_map_pkg::REG_NONE;
        repeat (4) @(posedge sys_clk);
        #1 chk(pc_addr, 24'h000000);
        @(negedge sys_clk);
        nrst = 1'b1;
        chk(pc_region.reset_vec, 1'b1);
        wr(16'h0800, 1'b0, 16'h1234, 2'b00);
        chk(wr_ptr_next, 16'h0802);
        wr(16'h0801, 1'b1, 16'h55AB, 2'b00);
        wr(16'h0010, 1'b0, 16'hBEEF, 2'b11);
        wr(16'h0011, 1'b1, 16'h0055, 2'b10);
        wr(16'h0010, 1'b1, 16'h0055, 2'b01);
        wr(16'h0801, 1'b0, 16'hFFFF, 2'b00);
        trap_chk(1'b0, 1'b1);
        wr(16'h0013, 1'b0, 16'hFFFF, 2'b00);
        trap_chk(1'b0, 1'b1);
        foreach (rows[i])
        begin
            processor_control_register = rows[i].w ? 16'h0004 : 16'h0000;
            rd(rows[i].n ? mem_map_pkg::AM_NEAR : mem_map_pkg::AM_FULL,
                rows[i].f, rows[i].b, 1'b0);
            chk(rd_data, rows[i].d);
            chk(rd_ptr_next, rows[i].p);
        end
        rd(mem_map_pkg::AM_INDIRECT, 16'h0800, 1'b0, 1'b1);
        chk(rd_ptr_next, 16'h07FE);
        rd(mem_map_pkg::AM_FULL, 16'h0801, 1'b0, 1'b0);
        chk(rd_data, 16'hAB34);
        trap_chk(1'b1, 1'b0);
        reg_op = mem_map_pkg::REG_BYTE;
        reg_old = 16'hC3C3;
        rd(mem_map_pkg::AM_FULL, 16'h0801, 1'b1, 1'b0);
        chk({reg_new_valid, reg_new}, {1'b1, 16'hC3AB});
        reg_op = mem_map_pkg::REG_NONE;
        ext(mem_map_pkg::REG_SIGN_EXT, 16'h0080, 16'hFF80);
        ext(mem_map_pkg::REG_SIGN_EXT, 16'h127F, 16'h007F);
        ext(mem_map_pkg::REG_ZERO_EXT, 16'h1280, 16'h0080);
        pcop(3'b100, 24'h000000, 24'h000002);
        pcop(3'b101, 24'h000000, 24'h000004);
        pcop(3'b001, 24'h000000, 24'h000002);
        pcop(3'b010, 24'h7FFFF1, 24'h7FFFF0);
        pcop(3'b010, 24'hFFFFFF, 24'h7FFFFE);
        for (int i = 0; i < 7; i++)
        begin
            tq(i ? 24'hF80002 + 24'(2 * i) : 24'hF80000);
            chk({tbl_ok, tbl_region.cfg, tbl_region.cfg_idx},
                {2'b11, i[2:0]});
        end
        tq(24'h7FFE02);
        chk({tbl_region.eeprom, tbl_region.ee_idx}, 9'h101);
        tq(24'h7FFFFE);
        chk({tbl_region.eeprom, tbl_region.ee_idx}, 9'h1FF);
        chk(vector_ptr, 24'h00000A);
        irq_alt_table = 1'b1;
        irq_source = 7'h7D;
        @(negedge sys_clk);
        chk({vector_ok, vector_ptr}, {1'b1, 24'h0001FE});
        // Second reset in mid-run must bring the counter home again
        nrst = 1'b0;
        #1 chk(pc_addr, 24'h000000);
        @(negedge sys_clk);
        nrst = 1'b1;
        pcop(3'b100, 24'h000000, 24'h000002);
        wrap_up();
    end
endmodule : memory_space_address_decode_tb
